// ===== core/dpu_pkg.sv
// dual data pointer unit package: addresses, fields, reset values, timing
package dpu_pkg;
   localparam logic [7:0] DPU_ADDR_PTR_LO   = 8'h82;
   localparam logic [7:0] DPU_ADDR_PTR_HI   = 8'h83;
   localparam logic [7:0] DPU_ADDR_AUX      = 8'ha2;
   localparam logic [7:0] DPU_ADDR_GUARD    = 8'hc7;
   localparam logic [7:0] DPU_GUARD_FIRST   = 8'haa;
   localparam logic [7:0] DPU_GUARD_SECOND  = 8'h55;
   localparam int         DPU_SEL_BIT       = 0;
   localparam int         DPU_ZERO_BIT      = 1;
   localparam int         DPU_SWAP_BIT      = 2;
   localparam int         DPU_FLAG_BIT      = 3;
   localparam int         DPU_HARD_BIT      = 5;
   localparam int         DPU_PIN_BIT       = 6;
   localparam int         DPU_SW_BIT        = 7;
   localparam logic [7:0] DPU_AUX_RESET     = 8'h00;
   localparam logic [7:0] DPU_AUX_KEEP_HI   = 8'he0;
   localparam logic [7:0] DPU_AUX_WR_MASK   = 8'hed;
   localparam logic [7:0] DPU_BYTE_RESET    = 8'h00;
   localparam logic [15:0] DPU_PTR_RESET    = 16'h0000;
   // guard timing, in core clock cycles
   localparam int         DPU_ARM_CYCLES    = 3;
   localparam int         DPU_OPEN_CYCLES   = 4;
   localparam int         DPU_CNT_W         = 3;

   typedef enum logic [2:0] {
      DPU_RST_NONE,
      DPU_RST_POWER,
      DPU_RST_SOFT,
      DPU_RST_PIN,
      DPU_RST_OTHER
   } dpu_rst_kind_t;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } dpu_sfr_req_t;

   typedef struct packed {
      logic        inc;
      logic        load;
      logic [15:0] value;
   } dpu_ptr_op_t;
endpackage

// ===== core/dpu_guard.sv
// timed-access guard: opens a short write window after two guard writes
`timescale 1ns/100ps
module dpu_guard
   import dpu_pkg::*;
(
   input  wire logic       i_mclk,
   input  wire logic       i_srst,
   input  wire logic       i_guard_wr,
   input  wire logic [7:0] i_guard_data,
   input  wire logic       i_prot_wr,
   output logic            o_open
);
   typedef enum logic [1:0] {DPU_G_IDLE, DPU_G_ARMED, DPU_G_OPEN} dpu_gstate_t;

   dpu_gstate_t          state_reg;
   logic [DPU_CNT_W-1:0] cnt_reg;

   assign o_open = (state_reg == DPU_G_OPEN);

   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         state_reg <= DPU_G_IDLE;
         cnt_reg   <= '0;
      end else begin
         case (state_reg)
            DPU_G_IDLE: begin
               if (i_guard_wr && i_guard_data == DPU_GUARD_FIRST) begin
                  state_reg <= DPU_G_ARMED;
                  cnt_reg   <= '0;
               end
            end
            DPU_G_ARMED: begin
               // second write must land within the arm span
               if (i_guard_wr && i_guard_data == DPU_GUARD_SECOND) begin
                  state_reg <= DPU_G_OPEN;
                  cnt_reg   <= '0;
               end else if (i_guard_wr && i_guard_data == DPU_GUARD_FIRST) begin
                  cnt_reg   <= '0;
               end else if (cnt_reg == DPU_CNT_W'(DPU_ARM_CYCLES - 1)) begin
                  state_reg <= DPU_G_IDLE;
               end else begin
                  cnt_reg   <= cnt_reg + 1'b1;
               end
            end
            DPU_G_OPEN: begin
               // one protected write per window, closes after open span
               if (i_prot_wr || cnt_reg == DPU_CNT_W'(DPU_OPEN_CYCLES - 1)) begin
                  state_reg <= DPU_G_IDLE;
               end else begin
                  cnt_reg   <= cnt_reg + 1'b1;
               end
            end
            default: state_reg <= DPU_G_IDLE;
         endcase
      end
   end
endmodule

// ===== core/dpu_top.sv
// dual data pointer unit: two pointers, auxiliary register, timed-access guard
// How it works
// - two 16-bit pointers; aux bit 0 selects, 0 picks pointer zero
// - switching select leaves the inactive pointer unchanged
// - aux bit 1 reads zero, so incrementing aux toggles the select
// - active pointer low byte at 82H, high byte at 83H, reset zero
// - active pointer drives indirect auxiliary RAM and program memory address
// - aux bit 3 is a free software flag with no hardware effect
// - power-on clears aux; soft sets bit 7, pin sets bit 6, others keep 7:5
// - window opens only if 55H follows AAH within 3 cycles
// - protected writes outside an open window are discarded
// - only the first protected write in a window succeeds
// - window stays open up to 4 cycles, closing on the first protected write
// - protected register reads always succeed
`timescale 1ns/100ps
module dpu_top
   import dpu_pkg::*;
(
   input  wire logic          i_mclk,
   input  wire logic          i_srst,
   input  wire dpu_rst_kind_t i_rst_kind,
   input  wire dpu_sfr_req_t  i_sfr,
   input  wire logic          i_prot_wr,
   input  wire dpu_ptr_op_t   i_ptr_op,
   output logic [7:0]         o_rdata,
   output logic               o_hit,
   output logic [15:0]        o_addr,
   output logic               o_sel,
   output logic               o_user_flag,
   output logic               o_serial_pin_swap,
   output logic               o_window_open,
   output logic               o_prot_wr_ok
);
   ////////////////////////////////////////////////////////////////////////////
   logic [15:0] pointer_zero_reg;
   logic [15:0] pointer_one_reg;
   logic [7:0]  aux_reg;
   logic [7:0]  aux_next;
   logic        guard_open;
   logic        sel;
   logic [15:0] active;
   logic [15:0] active_next;

   function automatic logic [15:0] dpu_update(input logic [15:0] cur,
                                               input dpu_sfr_req_t req,
                                               input dpu_ptr_op_t op);
      logic [15:0] v;
      v = cur;
      if (op.load) begin
         v = op.value;
      end else if (op.inc) begin
         v = cur + 16'h0001;
      end
      if (req.wr && req.addr == DPU_ADDR_PTR_LO) begin
         v[7:0] = req.wdata;
      end
      if (req.wr && req.addr == DPU_ADDR_PTR_HI) begin
         v[15:8] = req.wdata;
      end
      return v;
   endfunction

   assign sel         = aux_reg[DPU_SEL_BIT];
   assign active      = sel ? pointer_one_reg : pointer_zero_reg;
   assign active_next = dpu_update(active, i_sfr, i_ptr_op);

   ////////////////////////////////////////////////////////////////////////////
   dpu_guard u_guard (
      .i_mclk       (i_mclk),
      .i_srst       (i_srst),
      .i_guard_wr   (i_sfr.wr && i_sfr.addr == DPU_ADDR_GUARD),
      .i_guard_data (i_sfr.wdata),
      .i_prot_wr    (i_prot_wr),
      .o_open       (guard_open)
   );

   // protected write permission, reads never gated
   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         o_window_open <= 1'b0;
         o_prot_wr_ok  <= 1'b0;
      end else begin
         o_window_open <= guard_open;
         o_prot_wr_ok  <= i_prot_wr && guard_open;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // pointers: only the selected one changes
   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         pointer_zero_reg <= DPU_PTR_RESET;
         pointer_one_reg  <= DPU_PTR_RESET;
      end else if (sel) begin
         pointer_one_reg  <= active_next;
      end else begin
         pointer_zero_reg <= active_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // auxiliary register, reset cause flags
   always_comb begin
      aux_next = aux_reg;
      if (i_sfr.wr && i_sfr.addr == DPU_ADDR_AUX) begin
         aux_next = (aux_reg & ~DPU_AUX_WR_MASK) | (i_sfr.wdata & DPU_AUX_WR_MASK);
      end
      aux_next[DPU_ZERO_BIT] = 1'b0;
      aux_next[4]            = 1'b0;
   end

   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         case (i_rst_kind)
            DPU_RST_SOFT: begin
               aux_reg <= (aux_reg & DPU_AUX_KEEP_HI) | (8'h1 << DPU_SW_BIT);
               aux_reg[DPU_HARD_BIT] <= 1'b0;
            end
            DPU_RST_PIN: begin
               aux_reg <= (aux_reg & DPU_AUX_KEEP_HI) | (8'h1 << DPU_PIN_BIT);
               aux_reg[DPU_HARD_BIT] <= 1'b0;
            end
            DPU_RST_OTHER: aux_reg <= aux_reg & DPU_AUX_KEEP_HI;
            default:       aux_reg <= DPU_AUX_RESET;
         endcase
      end else begin
         aux_reg <= aux_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // registered outputs
   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         o_addr            <= DPU_PTR_RESET;
         o_sel             <= 1'b0;
         o_user_flag       <= 1'b0;
         o_serial_pin_swap <= 1'b0;
      end else begin
         o_addr            <= (aux_next[DPU_SEL_BIT] ? pointer_one_reg : pointer_zero_reg);
         if (aux_next[DPU_SEL_BIT] == sel) begin
            o_addr         <= active_next;
         end
         o_sel             <= aux_next[DPU_SEL_BIT];
         o_user_flag       <= aux_next[DPU_FLAG_BIT];
         o_serial_pin_swap <= aux_next[DPU_SWAP_BIT];
      end
   end

   // read port, answered one cycle after the request
   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         o_rdata <= DPU_BYTE_RESET;
         o_hit   <= 1'b0;
      end else begin
         o_rdata <= DPU_BYTE_RESET;
         o_hit   <= 1'b0;
         if (i_sfr.rd) begin
            case (i_sfr.addr)
               DPU_ADDR_PTR_LO: begin
                  o_rdata <= active[7:0];
                  o_hit   <= 1'b1;
               end
               DPU_ADDR_PTR_HI: begin
                  o_rdata <= active[15:8];
                  o_hit   <= 1'b1;
               end
               DPU_ADDR_AUX: begin
                  o_rdata <= aux_reg;
                  o_hit   <= 1'b1;
               end
               default: o_hit <= 1'b0;
            endcase
         end
      end
   end
endmodule

// ===== tb/dpu_checker.sv
// assertion checker for the dual data pointer unit
`timescale 1ns/100ps
module dpu_checker
   import dpu_pkg::*;
(
   input wire logic          i_mclk,
   input wire logic          i_srst,
   input wire dpu_rst_kind_t i_rst_kind,
   input wire dpu_sfr_req_t  i_sfr,
   input wire logic          i_prot_wr,
   input wire dpu_ptr_op_t   i_ptr_op,
   input wire logic [7:0]    o_rdata,
   input wire logic          o_hit,
   input wire logic [15:0]   o_addr,
   input wire logic          o_sel,
   input wire logic          o_user_flag,
   input wire logic          o_serial_pin_swap,
   input wire logic          o_window_open,
   input wire logic          o_prot_wr_ok
);
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (i_srst);
   logic g55;
   assign g55 = i_sfr.wr && i_sfr.addr == DPU_ADDR_GUARD && i_sfr.wdata == DPU_GUARD_SECOND;
   a_hit_addr: assert property (i_sfr.rd && (i_sfr.addr == DPU_ADDR_PTR_LO ||
      i_sfr.addr == DPU_ADDR_PTR_HI || i_sfr.addr == DPU_ADDR_AUX) |=> o_hit)
      else $error("read hit missing");
   a_idle_read: assert property (!i_sfr.rd |=> o_rdata == 8'h00 && !o_hit)
      else $error("read data without read");
   a_aux_view: assert property (i_sfr.rd && !i_sfr.wr && i_sfr.addr == DPU_ADDR_AUX
      |=> !o_rdata[1] && o_rdata[0] == o_sel && o_rdata[3] == o_user_flag)
      else $error("aux read mismatch");
   a_ok_cause: assert property (o_prot_wr_ok |-> $past(i_prot_wr))
      else $error("grant without write");
   a_ok_once: assert property (i_prot_wr && !i_sfr.wr ##1 i_prot_wr
      |=> !(o_prot_wr_ok && $past(o_prot_wr_ok)))
      else $error("two grants in one window");
   a_open_src: assert property ($rose(o_window_open)
      |-> $past(g55, 1) || $past(g55, 2) || $past(g55, 3))
      else $error("window opened without guard");
   a_open_len: assert property ($rose(o_window_open) |-> ##[1:4] !o_window_open)
      else $error("window open too long");
   a_load_sel: assert property (i_ptr_op.load && !i_sfr.wr
      |=> o_addr == $past(i_ptr_op.value))
      else $error("load not on active pointer");
   a_inc_sel: assert property (i_ptr_op.inc && !i_ptr_op.load && !i_sfr.wr
      |=> o_addr == 16'($past(o_addr) + 16'h0001))
      else $error("increment not on active pointer");
endmodule
bind dpu_top dpu_checker u_chk (.i_mclk, .i_srst, .i_rst_kind, .i_sfr, .i_prot_wr, .i_ptr_op,
   .o_rdata, .o_hit, .o_addr, .o_sel, .o_user_flag, .o_serial_pin_swap, .o_window_open,
   .o_prot_wr_ok);

// ===== tb/dpu_core_model.sv
// core-side model issuing special-register accesses and protected writes
`timescale 1ns/100ps
module dpu_core_model
   import dpu_pkg::*;
(
   input  wire logic    i_mclk,
   output dpu_sfr_req_t o_sfr,
   output logic         o_prot_wr
);
   initial begin
      o_sfr = '0;
      o_prot_wr = 1'b0;
   end
   // one request a cycle, changed at the falling edge, occupied addresses only
   task automatic op(input dpu_sfr_req_t r, input logic p);
      @(negedge i_mclk);
      o_sfr = r;
      o_prot_wr = p;
   endtask
endmodule

// ===== tb/testbench.sv
// self-checking bench for the dual data pointer unit
`timescale 1ns/100ps
module testbench;
   import dpu_pkg::*;
   localparam logic [7:0] LO = DPU_ADDR_PTR_LO, HI = DPU_ADDR_PTR_HI, AX = DPU_ADDR_AUX;
   logic          i_mclk = 1'b0;
   logic          i_srst = 1'b1;
   dpu_rst_kind_t i_rst_kind = DPU_RST_POWER;
   dpu_sfr_req_t  i_sfr;
   logic          i_prot_wr;
   dpu_ptr_op_t   i_ptr_op = '0;
   logic [7:0]    o_rdata;
   logic [15:0]   o_addr;
   logic          o_hit, o_sel, o_user_flag, o_serial_pin_swap, o_window_open, o_prot_wr_ok;
   int            n_fail = 0;
   int            checked = 0;
   dpu_top dut (.i_mclk, .i_srst, .i_rst_kind, .i_sfr, .i_prot_wr, .i_ptr_op, .o_rdata, .o_hit,
      .o_addr, .o_sel, .o_user_flag, .o_serial_pin_swap, .o_window_open, .o_prot_wr_ok);
   dpu_core_model core (.i_mclk, .o_sfr(i_sfr), .o_prot_wr(i_prot_wr));
   initial forever #20 i_mclk = ~i_mclk;
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         n_fail++;
         $display("Error %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic w(input logic [7:0] a, input logic [7:0] d);
      core.op({1'b1, 1'b0, a, d}, 1'b0);
   endtask
   task automatic idle(input logic p);
      core.op('0, p);
   endtask
   task automatic r(input logic [7:0] a, input logic [7:0] e);
      core.op({1'b0, 1'b1, a, 8'h00}, 1'b0);
      idle(1'b0);
      chk(o_rdata, e);
   endtask
   task automatic rst(input dpu_rst_kind_t k, input logic [7:0] e);
      @(negedge i_mclk);
      i_srst = 1'b1;
      i_rst_kind = k;
      @(negedge i_mclk);
      i_srst = 1'b0;
      i_rst_kind = DPU_RST_NONE;
      chk(o_addr, 16'h0000);
      r(AX, e);
   endtask
   task automatic po(input logic i, input logic l, input logic [15:0] v, input logic [15:0] e);
      @(negedge i_mclk);
      i_ptr_op = '{inc: i, load: l, value: v};
      @(negedge i_mclk);
      i_ptr_op = '0;
      chk(o_addr, e);
   endtask
   task automatic guard(input int g1, input int g2, input int np, input logic [3:0] e);
      w(DPU_ADDR_GUARD, DPU_GUARD_FIRST);
      repeat (g1) idle(1'b0);
      w(DPU_ADDR_GUARD, DPU_GUARD_SECOND);
      repeat (g2) idle(1'b0);
      for (int i = 0; i < np; i++) begin
         idle(1'b1);
         if (i > 0) chk(o_prot_wr_ok, e[i-1]);
      end
      idle(1'b0);
      chk(o_prot_wr_ok, e[np-1]);
      repeat (6) idle(1'b0);
   endtask
   task automatic t_ptr;
      r(LO, 8'h00);
      r(AX, 8'h00);
      w(LO, 8'h34);
      w(HI, 8'h12);
      idle(1'b0);
      chk(o_addr, 16'h1234);
      w(AX, 8'h01);
      w(LO, 8'hcd);
      w(HI, 8'hab);
      idle(1'b0);
      chk(o_addr, 16'habcd);
      w(AX, 8'h02);
      r(AX, 8'h00);
      r(LO, 8'h34);
      w(AX, 8'h0c);
      idle(1'b0);
      chk({o_user_flag, o_serial_pin_swap, o_addr}, 18'h31234);
   endtask
   task automatic t_op;
      po(1'b0, 1'b1, 16'h00ff, 16'h00ff);
      po(1'b1, 1'b0, 16'h0000, 16'h0100);
      w(AX, 8'h0d);
      idle(1'b0);
      chk(o_addr, 16'habcd);
      po(1'b1, 1'b0, 16'h0000, 16'habce);
      r(HI, 8'hab);
   endtask
   task automatic t_guard;
      guard(0, 0, 1, 4'h1);
      guard(2, 0, 1, 4'h1);
      guard(3, 0, 1, 4'h0);
      guard(0, 0, 2, 4'h1);
      guard(0, 3, 1, 4'h1);
      guard(0, 4, 1, 4'h0);
      idle(1'b1);
      idle(1'b0);
      chk(o_prot_wr_ok, 1'b0);
   endtask
   task automatic t_rst;
      rst(DPU_RST_PIN, 8'h40);
      rst(DPU_RST_SOFT, 8'hc0);
      w(AX, 8'hff);
      r(AX, 8'hed);
      rst(DPU_RST_OTHER, 8'he0);
      rst(DPU_RST_POWER, 8'h00);
   endtask
   task automatic conclude;
      if (n_fail == 0 && checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   initial begin
      repeat (10) @(negedge i_mclk);
      i_srst = 1'b0;
      i_rst_kind = DPU_RST_NONE;
      t_ptr;
      t_op;
      t_guard;
      t_rst;
      conclude;
   end
   initial begin
      repeat (3000) @(posedge i_mclk);
      n_fail++;
      conclude;
   end
endmodule
